// ===== logic/uart_intr_flow.sv
// Interrupt, enhanced feature and flow control logic of one UART channel
//
// Operation
// [R1] Enable bits 0-3 gate four basic interrupts
// [R2] Enable bit 4 selects sleep mode
// [R3] Enable bits 5-7 gate Xoff, RTS, CTS interrupts
// [R4] Upper enable bits writable only with write enable
// [R5] Re-enabling transmit interrupt creates no new event
// [R6] Identification bit 0 low while interrupt pending
// [R7] Identification bits 3:1 encode highest source
// [R8] Sources reported in fixed priority order
// [R9] Bits 4 and 5 flag Xoff and CTS/RTS
// [R10] Identification bits 7:6 mirror fifo enable
// [R11] Low feature bits select software flow mode
// [R12] Feature bit 4 gates enhanced bit writes
// [R13] Special character match sets identification bit 4
// [R14] Auto RTS follows halt and resume thresholds
// [R15] Auto CTS halts transmitter on high CTS
// [R16] Two bytes form the 16-bit baud divisor
// [R17] Software writes divisor before enabling sleep
// [R18] Threshold nibbles hold halt and resume levels
// [R19] Threshold writes need write enable and access
// [R20] Software keeps halt above resume threshold
// [R21] Software loads thresholds before enabling flow
// [R22] Interrupt output asserts on enabled source
// [R23] Modem control bit 6 opens threshold registers
// [R24] Nibble value N means 4N characters
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`include "uart_intr_flow_cfg.svh"

module uart_intr_flow (
  input  wire logic                             clk_in,
  input  wire logic                             rst_n_in,
  input  wire uart_intr_flow_pkg::reg_addr_t    addr_in,
  input  wire uart_intr_flow_pkg::byte_t        wdata_in,
  input  wire logic                             wr_in,
  input  wire logic                             rd_in,
  output logic [7:0]                            rdata_out,
  input  wire logic                             line_err_in,
  input  wire logic                             rx_timeout_in,
  input  wire logic                             rx_ready_in,
  input  wire logic                             tx_below_in,
  input  wire logic                             tx_write_in,
  input  wire logic                             modem_chg_in,
  input  wire logic                             rx_char_valid_in,
  input  wire uart_intr_flow_pkg::byte_t        rx_char_in,
  input  wire logic                             xoff_rcvd_in,
  input  wire uart_intr_flow_pkg::fifo_level_t  rx_level_in,
  input  wire logic                             cts_n_in,
  output logic                                  rts_n_out,
  output logic                                  tx_halt_out,
  output logic                                  irq_out,
  output logic                                  sleep_out,
  output logic [15:0]                           divisor_out,
  output logic [3:0]                            sw_flow_mode_out,
  output logic                                  fifo_en_out,
  output logic [7:0]                            trigger_level_out
);
  import uart_intr_flow_pkg::*;

  byte_t       interrupt_enable_reg;
  byte_t       enhanced_feature_ctrl_reg;
  byte_t       divisor_low_reg;
  byte_t       divisor_high_reg;
  byte_t       flow_threshold_ctrl_reg;
  byte_t       fifo_trigger_level_reg;
  byte_t       modem_control_reg;
  byte_t       fifo_control_reg;
  byte_t       xoff2_char_reg;
  byte_t       rdata_reg;
  byte_t       rdata_next;
  byte_t       source_id;
  logic        cts_meta_reg;
  logic        cts_sync_reg;
  logic        cts_prev_reg;
  logic        rts_n_reg;
  logic        rts_prev_reg;
  logic        tx_below_prev_reg;
  logic        tx_pend_reg;
  logic        xoff_flag_reg;
  logic        cts_chg_reg;
  logic        rts_chg_reg;
  logic        tx_halt_reg;
  logic        write_en;
  logic        ext_access;
  logic        id_read;
  logic        special_hit;
  logic [7:0]  halt_level;
  logic [7:0]  resume_level;
  logic [6:0]  src_vec;

  // Level of a threshold nibble in characters
  function automatic logic [7:0] nibble_level(input logic [3:0] nib);
    nibble_level = {2'b00, nib, 2'b00}; // R24
  endfunction : nibble_level

  // Priority encoder from enabled sources to identification bits 5:0
  function automatic logic [5:0] id_code(input logic [6:0] src);
    if (src[0]) begin
      id_code = `ID_LINE_ERR; // R7
    end else if (src[1]) begin
      id_code = `ID_RX_TIMEOUT;
    end else if (src[2]) begin
      id_code = `ID_RX_DATA;
    end else if (src[3]) begin
      id_code = `ID_TX_HOLD;
    end else if (src[4]) begin
      id_code = `ID_MODEM;
    end else if (src[5]) begin
      id_code = `ID_XOFF;
    end else if (src[6]) begin
      id_code = `ID_CTS_RTS;
    end else begin
      id_code = `ID_NONE;
    end
  endfunction : id_code

  // Access qualifiers shared by the register writes
  assign write_en   = enhanced_feature_ctrl_reg[`EF_WRITE_EN]; // R12
  assign ext_access = modem_control_reg[`MC_EXT_ACCESS]; // R23
  assign id_read    = rd_in && (addr_in == `OFS_SOURCE_ID_FIFO);
  assign special_hit = enhanced_feature_ctrl_reg[`EF_SPECIAL] &&
                       rx_char_valid_in && (rx_char_in == xoff2_char_reg);
  assign halt_level   = nibble_level(flow_threshold_ctrl_reg[3:0]); // R18
  assign resume_level = nibble_level(flow_threshold_ctrl_reg[7:4]); // R18

  // Enabled interrupt sources, index is priority
  always_comb begin
    src_vec[0] = line_err_in && interrupt_enable_reg[`IE_LINE_STAT]; // R1
    src_vec[1] = rx_timeout_in && interrupt_enable_reg[`IE_RX_DATA]; // R1
    src_vec[2] = rx_ready_in && interrupt_enable_reg[`IE_RX_DATA]; // R1
    src_vec[3] = tx_pend_reg && interrupt_enable_reg[`IE_TX_HOLD]; // R1
    src_vec[4] = modem_chg_in && interrupt_enable_reg[`IE_MODEM_STAT]; // R1
    src_vec[5] = xoff_flag_reg && interrupt_enable_reg[`IE_XOFF]; // R3
    src_vec[6] = (rts_chg_reg && interrupt_enable_reg[`IE_RTS]) ||
                 (cts_chg_reg && interrupt_enable_reg[`IE_CTS]); // R3
  end

  // Identification byte: fifo mirror, flags, encoded source, pending
  always_comb begin
    source_id      = {{2{fifo_control_reg[`FC_FIFO_EN]}}, id_code(src_vec)};
    source_id[7:6] = {2{fifo_control_reg[`FC_FIFO_EN]}}; // R10
    source_id[4]   = src_vec[5]; // R9
    source_id[5]   = src_vec[6] && !src_vec[5]; // R9
    if (|src_vec[4:0]) begin
      source_id[5:4] = 2'b00; // R8
    end
  end

  // Interrupt output follows any enabled pending source
  assign irq_out = |src_vec; // R22

  // Interrupt enable register, upper half guarded
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      interrupt_enable_reg <= `RST_BYTE;
    end else if (wr_in && addr_in == `OFS_INTERRUPT_ENABLE) begin
      interrupt_enable_reg[3:0] <= wdata_in[3:0]; // R1
      if (write_en) begin
        interrupt_enable_reg[7:4] <= wdata_in[7:4]; // R4
      end
    end
  end

  // Enhanced feature register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      enhanced_feature_ctrl_reg <= `RST_BYTE;
    end else if (wr_in && addr_in == `OFS_ENHANCED_FEATURE) begin
      enhanced_feature_ctrl_reg <= wdata_in; // R11
    end
  end

  // Modem control, upper bits guarded
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      modem_control_reg <= `RST_BYTE;
    end else if (wr_in && addr_in == `OFS_MODEM_CONTROL) begin
      modem_control_reg[4:0] <= wdata_in[4:0];
      if (write_en) begin
        modem_control_reg[7:5] <= wdata_in[7:5]; // R12
      end
    end
  end

  // Fifo control shares the identification address on writes
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fifo_control_reg <= `RST_BYTE;
    end else if (wr_in && addr_in == `OFS_SOURCE_ID_FIFO) begin
      fifo_control_reg[3:0] <= wdata_in[3:0];
      fifo_control_reg[7:6] <= wdata_in[7:6];
      if (write_en) begin
        fifo_control_reg[5:4] <= wdata_in[5:4]; // R12
      end
    end
  end

  // Divisor bytes
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      divisor_low_reg  <= `RST_BYTE;
      divisor_high_reg <= `RST_BYTE;
    end else if (wr_in && addr_in == `OFS_DIVISOR_LOW) begin
      divisor_low_reg <= wdata_in; // R16
    end else if (wr_in && addr_in == `OFS_DIVISOR_HIGH) begin
      divisor_high_reg <= wdata_in; // R16
    end
  end

  // Threshold and trigger registers open only with extended access
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flow_threshold_ctrl_reg <= `RST_BYTE;
      fifo_trigger_level_reg  <= `RST_BYTE;
      xoff2_char_reg          <= `RST_BYTE;
    end else if (wr_in && addr_in == `OFS_THRESHOLD_XOFF2) begin
      if (ext_access) begin
        if (write_en) begin
          flow_threshold_ctrl_reg <= wdata_in; // R19
        end
      end else begin
        xoff2_char_reg <= wdata_in;
      end
    end else if (wr_in && addr_in == `OFS_TRIGGER_LEVEL) begin
      if (ext_access && write_en) begin
        fifo_trigger_level_reg <= wdata_in; // R23
      end
    end
  end

  // Read mux, data stands one cycle after the strobe
  always_comb begin
    rdata_next = `RST_READ_DATA;
    unique case (addr_in)
      `OFS_DIVISOR_LOW:      rdata_next = divisor_low_reg;
      `OFS_DIVISOR_HIGH:     rdata_next = divisor_high_reg;
      `OFS_INTERRUPT_ENABLE: rdata_next = interrupt_enable_reg;
      `OFS_SOURCE_ID_FIFO:   rdata_next = source_id; // R6
      `OFS_MODEM_CONTROL:    rdata_next = modem_control_reg;
      `OFS_ENHANCED_FEATURE: rdata_next = enhanced_feature_ctrl_reg;
      `OFS_THRESHOLD_XOFF2: begin
        rdata_next = ext_access ? flow_threshold_ctrl_reg : xoff2_char_reg;
      end
      `OFS_TRIGGER_LEVEL: begin
        rdata_next = ext_access ? fifo_trigger_level_reg : `RST_READ_DATA;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_reg <= `RST_READ_DATA;
    end else if (rd_in) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= `RST_READ_DATA;
    end
  end

  // CTS pin synchroniser and edge history
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cts_meta_reg <= 1'b1;
      cts_sync_reg <= 1'b1;
      cts_prev_reg <= 1'b1;
    end else begin
      cts_meta_reg <= cts_n_in;
      cts_sync_reg <= cts_meta_reg;
      cts_prev_reg <= cts_sync_reg;
    end
  end

  // Transmit holding event: only a fresh drop below threshold counts
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_below_prev_reg <= 1'b0;
      tx_pend_reg       <= 1'b0;
    end else begin
      tx_below_prev_reg <= tx_below_in;
      if (tx_below_in && !tx_below_prev_reg &&
          interrupt_enable_reg[`IE_TX_HOLD]) begin
        tx_pend_reg <= 1'b1; // R5
      end else if (tx_write_in ||
                   (id_read && source_id[5:0] == `ID_TX_HOLD)) begin
        tx_pend_reg <= 1'b0;
      end
    end
  end

  // Sticky Xoff and special character flag, set wins over clear
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      xoff_flag_reg <= 1'b0;
    end else if (special_hit || xoff_rcvd_in) begin
      xoff_flag_reg <= 1'b1; // R13
    end else if (id_read && source_id[4]) begin
      xoff_flag_reg <= 1'b0;
    end
  end

  // Sticky CTS and RTS inactive-going flags, set wins over clear
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cts_chg_reg  <= 1'b0;
      rts_chg_reg  <= 1'b0;
      rts_prev_reg <= 1'b1;
    end else begin
      rts_prev_reg <= rts_n_reg;
      if (cts_sync_reg && !cts_prev_reg) begin
        cts_chg_reg <= 1'b1; // R9
      end else if (id_read && source_id[5]) begin
        cts_chg_reg <= 1'b0;
      end
      if (rts_n_reg && !rts_prev_reg) begin
        rts_chg_reg <= 1'b1; // R9
      end else if (id_read && source_id[5]) begin
        rts_chg_reg <= 1'b0;
      end
    end
  end

  // RTS pin: hysteresis on receive level or software forced level
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rts_n_reg <= 1'b1;
    end else if (enhanced_feature_ctrl_reg[`EF_AUTO_RTS]) begin
      if ({1'b0, rx_level_in} >= halt_level) begin
        rts_n_reg <= 1'b1; // R14
      end else if ({1'b0, rx_level_in} <= resume_level) begin
        rts_n_reg <= 1'b0; // R14
      end
    end else begin
      rts_n_reg <= !modem_control_reg[`MC_RTS_FORCE];
    end
  end

  // Transmitter halt while CTS is inactive
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_halt_reg <= 1'b0;
    end else begin
      tx_halt_reg <= enhanced_feature_ctrl_reg[`EF_AUTO_CTS] &&
                     cts_sync_reg; // R15
    end
  end

  // Outputs
  assign rdata_out         = rdata_reg;
  assign rts_n_out         = rts_n_reg;
  assign tx_halt_out       = tx_halt_reg;
  assign sleep_out         = interrupt_enable_reg[`IE_SLEEP]; // R2
  assign divisor_out       = {divisor_high_reg, divisor_low_reg}; // R16
  assign sw_flow_mode_out  = enhanced_feature_ctrl_reg[3:0]; // R11
  assign fifo_en_out       = fifo_control_reg[`FC_FIFO_EN];
  assign trigger_level_out = fifo_trigger_level_reg;

  // Checks
  property p_upper_enable_guard;
    @(posedge clk_in) disable iff (!rst_n_in)
    (wr_in && addr_in == `OFS_INTERRUPT_ENABLE && !write_en)
      |=> interrupt_enable_reg[7:4] == $past(interrupt_enable_reg[7:4]);
  endproperty
  a_upper_enable_guard: assert property (p_upper_enable_guard) // R4
    else $error("upper enable bits changed without write enable");

  property p_threshold_guard;
    @(posedge clk_in) disable iff (!rst_n_in)
    (wr_in && addr_in == `OFS_THRESHOLD_XOFF2 && !(write_en && ext_access))
      |=> $stable(flow_threshold_ctrl_reg);
  endproperty
  a_threshold_guard: assert property (p_threshold_guard) // R19
    else $error("threshold register written while locked");

  property p_line_err_code;
    @(posedge clk_in) disable iff (!rst_n_in)
    (line_err_in && interrupt_enable_reg[`IE_LINE_STAT])
      |-> source_id[3:0] == 4'h6 && irq_out;
  endproperty
  a_line_err_code: assert property (p_line_err_code) // R7
    else $error("line error not reported first");

  property p_pending_bit;
    @(posedge clk_in) disable iff (!rst_n_in)
    (id_read) |=> rdata_out[0] == !$past(irq_out) &&
                  rdata_out[7:6] == {2{$past(fifo_en_out)}};
  endproperty
  a_pending_bit: assert property (p_pending_bit) // R6
    else $error("identification read does not match pending state");

  property p_divisor_load;
    @(posedge clk_in) disable iff (!rst_n_in)
    (wr_in && addr_in == `OFS_DIVISOR_HIGH)
      |=> divisor_out[15:8] == $past(wdata_in) && $stable(divisor_out[7:0]);
  endproperty
  a_divisor_load: assert property (p_divisor_load) // R16
    else $error("divisor high byte not loaded");

  property p_special_char;
    @(posedge clk_in) disable iff (!rst_n_in)
    (special_hit && interrupt_enable_reg[`IE_XOFF] && !(|src_vec[4:0]))
      |=> source_id[4] || $past(id_read);
  endproperty
  a_special_char: assert property (p_special_char) // R13
    else $error("special character match not flagged");

  property p_auto_rts_halt;
    @(posedge clk_in) disable iff (!rst_n_in)
    (enhanced_feature_ctrl_reg[`EF_AUTO_RTS] &&
     {1'b0, rx_level_in} >= halt_level) |=> rts_n_out;
  endproperty
  a_auto_rts_halt: assert property (p_auto_rts_halt) // R14
    else $error("RTS not raised at halt level");

  property p_auto_cts;
    @(posedge clk_in) disable iff (!rst_n_in)
    (enhanced_feature_ctrl_reg[`EF_AUTO_CTS] && cts_n_in)[*4]
      |-> tx_halt_out;
  endproperty
  a_auto_cts: assert property (p_auto_cts) // R15
    else $error("transmitter not halted on high CTS");

  property p_no_refire;
    @(posedge clk_in) disable iff (!rst_n_in)
    (!tx_pend_reg && tx_below_in && tx_below_prev_reg) |=> !tx_pend_reg;
  endproperty
  a_no_refire: assert property (p_no_refire) // R5
    else $error("transmit interrupt raised without a fresh drop");

endmodule : uart_intr_flow

// ===== common/uart_intr_flow_cfg.svh
// Register offsets, field positions and reset values of the control block
`ifndef UART_INTR_FLOW_CFG_SVH
`define UART_INTR_FLOW_CFG_SVH

// Register offsets on the 3-bit register port
`define OFS_DIVISOR_LOW       3'h0
`define OFS_DIVISOR_HIGH      3'h1
`define OFS_INTERRUPT_ENABLE  3'h2
`define OFS_SOURCE_ID_FIFO    3'h3
`define OFS_MODEM_CONTROL     3'h4
`define OFS_ENHANCED_FEATURE  3'h5
`define OFS_THRESHOLD_XOFF2   3'h6
`define OFS_TRIGGER_LEVEL     3'h7

// Interrupt enable fields
`define IE_RX_DATA     0
`define IE_TX_HOLD     1
`define IE_LINE_STAT   2
`define IE_MODEM_STAT  3
`define IE_SLEEP       4
`define IE_XOFF        5
`define IE_RTS         6
`define IE_CTS         7

// Enhanced feature fields
`define EF_WRITE_EN    4
`define EF_SPECIAL     5
`define EF_AUTO_RTS    6
`define EF_AUTO_CTS    7

// Modem and fifo control fields
`define MC_RTS_FORCE   1
`define MC_EXT_ACCESS  6
`define FC_FIFO_EN     0

// Interrupt identification codes, bits 5:0
`define ID_NONE        6'h01
`define ID_LINE_ERR    6'h06
`define ID_RX_TIMEOUT  6'h0C
`define ID_RX_DATA     6'h04
`define ID_TX_HOLD     6'h02
`define ID_MODEM       6'h00
`define ID_XOFF        6'h10
`define ID_CTS_RTS     6'h20

// Reset values
`define RST_BYTE       8'h00
`define RST_READ_DATA  8'h00

`endif

// ===== common/uart_intr_flow_pkg.sv
// Types shared by the interrupt and flow control block
package uart_intr_flow_pkg;
  typedef logic [2:0] reg_addr_t;
  typedef logic [7:0] byte_t;
  typedef logic [6:0] fifo_level_t;
endpackage : uart_intr_flow_pkg

// ===== tb/remote_modem.sv
// Remote modem model facing the CTS and RTS pins of one channel
`timescale 1ns/1ns

module remote_modem (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic pause_in,
  input  wire logic rts_n_in,
  output logic      cts_n_out,
  output logic      may_send_out
);
  // CTS goes inactive high one cycle after a pause is commanded
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cts_n_out <= 1'b0;
    end else begin
      cts_n_out <= pause_in;
    end
  end

  // The remote end may only send while the device holds RTS low
  assign may_send_out = !rts_n_in;
endmodule : remote_modem

// ===== tb/uart_interrupt_flow_control_tb.sv
// Self-checking testbench of the interrupt and flow control block
`timescale 1ns/1ns

module uart_interrupt_flow_control_tb;
  import uart_intr_flow_pkg::*;
  logic        clk_in, rst_n_in, wr_in, rd_in, pause;
  logic        line_err_in, rx_timeout_in, rx_ready_in, modem_chg_in;
  logic        tx_below_in, tx_write_in, rx_char_valid_in, xoff_rcvd_in;
  logic        cts_n_in, rts_n_out, tx_halt_out, irq_out;
  logic        sleep_out, fifo_en_out, may_send;
  reg_addr_t   addr_in;
  byte_t       wdata_in, rx_char_in;
  fifo_level_t rx_level_in;
  logic [7:0]  rdata_out, trigger_level_out;
  logic [15:0] divisor_out;
  logic [3:0]  sw_flow_mode_out;
  int          num_errors, samples_checked;

  uart_intr_flow DUT (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .line_err_in(line_err_in),
    .rx_timeout_in(rx_timeout_in), .rx_ready_in(rx_ready_in),
    .tx_below_in(tx_below_in), .tx_write_in(tx_write_in),
    .modem_chg_in(modem_chg_in), .rx_char_valid_in(rx_char_valid_in),
    .rx_char_in(rx_char_in), .xoff_rcvd_in(xoff_rcvd_in),
    .rx_level_in(rx_level_in), .cts_n_in(cts_n_in),
    .rts_n_out(rts_n_out), .tx_halt_out(tx_halt_out),
    .irq_out(irq_out), .sleep_out(sleep_out),
    .divisor_out(divisor_out), .sw_flow_mode_out(sw_flow_mode_out),
    .fifo_en_out(fifo_en_out), .trigger_level_out(trigger_level_out)
  );

  remote_modem modem (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .pause_in(pause),
    .rts_n_in(rts_n_out), .cts_n_out(cts_n_in), .may_send_out(may_send)
  );

  // 50 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // Compare and count
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task print_verdict;
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  // Wait n edges and let their updates land
  task cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : cyc

  task wr(input reg_addr_t a, input byte_t d);
    @(posedge clk_in);
    wr_in    <= 1'b1;
    addr_in  <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task rd(input reg_addr_t a, input byte_t e);
    @(posedge clk_in);
    rd_in   <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk(rdata_out, e);
  endtask : rd

  task chr(input byte_t c);
    @(posedge clk_in);
    rx_char_in       <= c;
    rx_char_valid_in <= 1'b1;
    @(posedge clk_in);
    rx_char_valid_in <= 1'b0;
  endtask : chr

  task t_reset;
    rd(3'h3, 8'h01);
    rd(3'h2, 8'h00);
    chk(rts_n_out, 1'b1);
    chk(tx_halt_out, 1'b0);
    chk(irq_out, 1'b0);
  endtask : t_reset

  // Divisor loaded while sleep is still off
  task t_div;
    wr(3'h0, 8'h34);
    wr(3'h1, 8'h12);
    chk(divisor_out, 16'h1234);
  endtask : t_div

  task t_guard;
    wr(3'h2, 8'hFF);
    rd(3'h2, 8'h0F);
    wr(3'h5, 8'h1A);
    chk(sw_flow_mode_out, 4'hA);
    wr(3'h2, 8'hFF);
    rd(3'h2, 8'hFF);
    chk(sleep_out, 1'b1);
    wr(3'h2, 8'hEF);
    chk(sleep_out, 1'b0);
  endtask : t_guard

  // Four basic sources pending, dropped one by one from the top
  task t_prio;
    logic [7:0] code [5];
    logic [7:0] en [5];
    logic [7:0] one [5];
    code = '{8'h06, 8'h0C, 8'h04, 8'h00, 8'h01};
    en   = '{8'hE1, 8'hE2, 8'hE4, 8'hE8, 8'hE0};
    one  = '{8'h0C, 8'h01, 8'h06, 8'h00, 8'h01};
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_in);
      {line_err_in, rx_timeout_in, rx_ready_in, modem_chg_in} <= 4'hF >> i;
      rd(3'h3, code[i]);
      chk(irq_out, i < 4);
    end
    @(posedge clk_in);
    {line_err_in, rx_timeout_in, rx_ready_in, modem_chg_in} <= 4'hF;
    for (int i = 0; i < 5; i++) begin
      wr(3'h2, en[i]);
      rd(3'h3, one[i]);
      chk(irq_out, one[i] != 8'h01);
    end
    @(posedge clk_in);
    {line_err_in, rx_timeout_in, rx_ready_in, modem_chg_in} <= 4'h0;
    wr(3'h2, 8'hEF);
  endtask : t_prio

  task t_tx;
    @(posedge clk_in);
    tx_below_in <= 1'b1;
    rd(3'h3, 8'h02);
    rd(3'h3, 8'h01);
    wr(3'h2, 8'hED);
    wr(3'h2, 8'hEF);
    rd(3'h3, 8'h01);
    @(posedge clk_in);
    tx_below_in <= 1'b0;
    @(posedge clk_in);
    tx_below_in <= 1'b1;
    cyc(1);
    chk(irq_out, 1'b1);
    @(posedge clk_in);
    tx_write_in <= 1'b1;
    @(posedge clk_in);
    tx_write_in <= 1'b0;
    tx_below_in <= 1'b0;
    rd(3'h3, 8'h01);
  endtask : t_tx

  task t_xoff;
    wr(3'h6, 8'h5A);
    wr(3'h5, 8'h3A);
    chr(8'h5B);
    rd(3'h3, 8'h01);
    chr(8'h5A);
    rd(3'h3, 8'h10);
    rd(3'h3, 8'h01);
    @(posedge clk_in);
    xoff_rcvd_in <= 1'b1;
    @(posedge clk_in);
    xoff_rcvd_in <= 1'b0;
    wr(3'h2, 8'hCF);
    rd(3'h3, 8'h01);
    wr(3'h2, 8'hEF);
    rd(3'h3, 8'h10);
  endtask : t_xoff

  task t_rts;
    logic [6:0] lv [4];
    logic       ex [4];
    lv = '{7'd31, 7'd32, 7'd9, 7'd8};
    ex = '{1'b0, 1'b1, 1'b1, 1'b0};
    wr(3'h3, 8'h01);
    chk(fifo_en_out, 1'b1);
    rd(3'h3, 8'hC1);
    wr(3'h4, 8'h42);
    cyc(1);
    chk(rts_n_out, 1'b0);
    chk(may_send, 1'b1);
    wr(3'h7, 8'h35);
    chk(trigger_level_out, 8'h35);
    // Halt 32 above resume 8, loaded before auto RTS is on
    wr(3'h6, 8'h28);
    wr(3'h5, 8'h5A);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      rx_level_in <= lv[i];
      cyc(1);
      chk(rts_n_out, ex[i]);
      chk(may_send, !ex[i]);
    end
    rd(3'h3, 8'hE0);
    rd(3'h3, 8'hC1);
    wr(3'h5, 8'h4A);
    wr(3'h6, 8'h11);
    @(posedge clk_in);
    rx_level_in <= 7'd4;
    cyc(2);
    chk(rts_n_out, 1'b0);
  endtask : t_rts

  task t_cts;
    wr(3'h5, 8'h9A);
    @(posedge clk_in);
    rx_level_in <= 7'd0;
    pause       <= 1'b1;
    cyc(3);
    chk(tx_halt_out, 1'b0);
    cyc(1);
    chk(tx_halt_out, 1'b1);
    rd(3'h3, 8'hE0);
    rd(3'h3, 8'hC1);
    @(posedge clk_in);
    pause <= 1'b0;
    cyc(4);
    chk(tx_halt_out, 1'b0);
  endtask : t_cts

  // Hang guard, far beyond the some 160 cycles the tests need
  initial begin
    #400000;
    num_errors++;
    print_verdict();
  end

  initial begin
    {rst_n_in, wr_in, rd_in, pause, line_err_in, rx_timeout_in} = 6'h00;
    {rx_ready_in, modem_chg_in, tx_below_in, tx_write_in} = 4'h0;
    {rx_char_valid_in, xoff_rcvd_in} = 2'b00;
    addr_in     = 3'h0;
    wdata_in    = 8'h00;
    rx_char_in  = 8'h00;
    rx_level_in = 7'd0;
    num_errors  = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_div();
    t_guard();
    t_prio();
    t_tx();
    t_xoff();
    t_rts();
    t_cts();
    print_verdict();
  end
endmodule : uart_interrupt_flow_control_tb
